//--- rtl/pbc_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pbc_regs.svh"
// Overview of operation
// - Raise a break request whenever the fetch address meets a channel condition.
// - Break request is non-maskable; no enable or mask gates it.
// - Four channels A to D, each matched independently.
// - Condition combines address compare with cycle type qualifier fields.
// - Request is issued the cycle after the fetch, before it executes.
// - High half of break address supplies compare bits 31 to 16.
// - Low half of break address supplies compare bits 15 to 0.
// - Module stop bit halts all matching under software control.
// - Match flag is sticky; cleared by reading 1 then writing 0.
// - CPU cycle select 000 disables, 001 qualifies on CPU cycles.
// - Condition select 00 disables, 01 selects program counter break.
// - No matches are detected while in any standby state; the code sees standby through a two-flop synchroniser, two cycles late.
module pbc_top
  import pbc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [31:0] pc,
  input wire logic pc_valid,
  input wire logic standby,
  input wire logic [21:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [21:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic break_req,
  output logic irq
);
  // ****************************************
  // Index tables per channel
  // ****************************************
  localparam pbc_idx_t IDX_BAH[4] = '{`PBC_IDX_A_BAH, `PBC_IDX_B_BAH,
                                      `PBC_IDX_C_BAH, `PBC_IDX_D_BAH};
  localparam pbc_idx_t IDX_BAL[4] = '{`PBC_IDX_A_BAL, `PBC_IDX_B_BAL,
                                      `PBC_IDX_C_BAL, `PBC_IDX_D_BAL};
  localparam pbc_idx_t IDX_BMH[4] = '{`PBC_IDX_A_BMH, `PBC_IDX_B_BMH,
                                      `PBC_IDX_C_BMH, `PBC_IDX_D_BMH};
  localparam pbc_idx_t IDX_BML[4] = '{`PBC_IDX_A_BML, `PBC_IDX_B_BML,
                                      `PBC_IDX_C_BML, `PBC_IDX_D_BML};
  localparam pbc_idx_t IDX_CTL[4] = '{`PBC_IDX_A_CTL, `PBC_IDX_B_CTL,
                                      `PBC_IDX_C_CTL, `PBC_IDX_D_CTL};
  // ****************************************
  // Declarations
  // ****************************************
  pbc_chan_s chan_reg[4];
  logic [3:0] cmf_reg;
  logic [3:0] armed_reg;
  logic [3:0] hit;
  logic [3:0] stat_reg;
  logic [3:0] ien_reg;
  logic stop_reg;
  logic stby_meta_reg;
  logic stby_sync_reg;
  logic aw_full_reg;
  logic w_full_reg;
  pbc_idx_t aw_idx_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic rd_fire;
  pbc_idx_t ar_idx;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic run;
  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16
  // Decode check shared by both bus directions
  function automatic logic mapped(input pbc_idx_t idx);
    logic ok;
    ok = (idx == `PBC_IDX_STAT) || (idx == `PBC_IDX_CLR) ||
         (idx == `PBC_IDX_IEN) || (idx == `PBC_IDX_STOP);
    for (int i = 0; i < 4; i++) begin
      ok = ok || (idx == IDX_BAH[i]) || (idx == IDX_BAL[i]) ||
           (idx == IDX_BMH[i]) || (idx == IDX_BML[i]) ||
           (idx == IDX_CTL[i]);
    end
    return ok;
  endfunction : mapped
  // ****************************************
  // Standby synchroniser
  // ****************************************
  // Standby comes from the power controller domain
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stby_meta_reg <= 1'b0;
      stby_sync_reg <= 1'b0;
    end else if (ce) begin
      stby_meta_reg <= standby;
      stby_sync_reg <= stby_meta_reg;
    end
  end
  // Matching runs only out of stop and standby
  assign run = !stop_reg && !stby_sync_reg;
  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign ar_idx = s_axi_araddr[21:2];
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ok = mapped(aw_idx_reg);
  // Address and data held apart; either may arrive first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_idx_reg <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx_reg <= s_axi_awaddr[21:2];
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end
  // Write data holding stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      w_full_reg <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Response; unmapped writes are dropped with an error
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBC_RESP_OK;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `PBC_RESP_OK : `PBC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // Channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_chan
      logic wr_ctl;
      logic [15:0] ctl_new;
      assign wr_ctl = wr_fire && (aw_idx_reg == IDX_CTL[g]);
      assign ctl_new = merge16({4'h0, chan_reg[g].ctrl.cp, 3'h0, chan_reg[g].ctrl.id,
                                chan_reg[g].ctrl.rw, 2'h0}, w_data_reg, w_strb_reg);
      // Masked compare over both halves, gated by the two selects
      assign hit[g] = pc_valid && run &&
        (chan_reg[g].ctrl.cp == `PBC_CP_CPU) &&
        (chan_reg[g].ctrl.id == `PBC_ID_PC) &&
        (((pc ^ chan_reg[g].addr) & ~chan_reg[g].mask) == '0);
      // Address, mask and control storage
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          chan_reg[g].addr <= {`PBC_RST16, `PBC_RST16};
          chan_reg[g].mask <= {`PBC_RST16, `PBC_RST16};
          chan_reg[g].ctrl <= '0;
        end else if (ce && wr_fire) begin
          if (aw_idx_reg == IDX_BAH[g]) begin
            chan_reg[g].addr[31:16] <= merge16(chan_reg[g].addr[31:16],
                                               w_data_reg, w_strb_reg);
          end
          if (aw_idx_reg == IDX_BAL[g]) begin
            chan_reg[g].addr[15:0] <= merge16(chan_reg[g].addr[15:0],
                                              w_data_reg, w_strb_reg);
          end
          if (aw_idx_reg == IDX_BMH[g]) begin
            chan_reg[g].mask[31:16] <= merge16(chan_reg[g].mask[31:16],
                                               w_data_reg, w_strb_reg);
          end
          if (aw_idx_reg == IDX_BML[g]) begin
            chan_reg[g].mask[15:0] <= merge16(chan_reg[g].mask[15:0],
                                              w_data_reg, w_strb_reg);
          end
          if (wr_ctl) begin
            chan_reg[g].ctrl.cp <= ctl_new[`PBC_CP_MSB:`PBC_CP_LSB];
            chan_reg[g].ctrl.id <= ctl_new[`PBC_ID_MSB:`PBC_ID_LSB];
            chan_reg[g].ctrl.rw <= ctl_new[`PBC_RW_MSB:`PBC_RW_LSB];
          end
        end
      end
      // Sticky match flag; a new match beats a same-cycle clear
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          cmf_reg[g] <= 1'b0;
          armed_reg[g] <= 1'b0;
        end else if (ce) begin
          if (hit[g]) begin
            cmf_reg[g] <= 1'b1;
          end else if (wr_ctl && armed_reg[g] && w_strb_reg[1] &&
                       !w_data_reg[`PBC_CMF_BIT]) begin
            cmf_reg[g] <= 1'b0;
          end
          // Clear needs a prior read of 1, so stray writes are harmless
          if (rd_fire && ar_idx == IDX_CTL[g] && cmf_reg[g]) begin
            armed_reg[g] <= 1'b1;
          end else if (wr_ctl) begin
            armed_reg[g] <= 1'b0;
          end
        end
      end
      // ****************************************
      // Channel checks
      // ****************************************
      a_hit_flag_set:
        assert property (@(posedge clock) disable iff (!reset_n)
          ce && hit[g] |=> cmf_reg[g])
        else $error("match did not set flag");
      a_flag_sticky_hold:
        assert property (@(posedge clock) disable iff (!reset_n)
          cmf_reg[g] && !(ce && wr_ctl) |=> cmf_reg[g])
        else $error("flag dropped without clear");
      a_cp_sel_gate:
        assert property (@(posedge clock) disable iff (!reset_n)
          chan_reg[g].ctrl.cp != `PBC_CP_CPU |-> !hit[g])
        else $error("match with cpu select off");
      a_id_sel_gate:
        assert property (@(posedge clock) disable iff (!reset_n)
          chan_reg[g].ctrl.id != `PBC_ID_PC |-> !hit[g])
        else $error("match with pc select off");
      a_masked_addr_cmp:
        assert property (@(posedge clock) disable iff (!reset_n)
          hit[g] |-> ((pc[31:16] ^ chan_reg[g].addr[31:16]) &
                      ~chan_reg[g].mask[31:16]) == 16'h0000 &&
                     ((pc[15:0] ^ chan_reg[g].addr[15:0]) &
                      ~chan_reg[g].mask[15:0]) == 16'h0000)
        else $error("match on differing address");
    end
  endgenerate
  // ****************************************
  // Break request, status and interrupt
  // ****************************************
  // One-cycle request per matching fetch; never gated by enables
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      break_req <= 1'b0;
    end else if (ce) begin
      break_req <= |hit;
    end
  end
  // Sticky status; set wins over a write-one clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= 4'h0;
      ien_reg <= 4'h0;
      stop_reg <= 1'b0;
    end else if (ce) begin
      if (wr_fire && aw_idx_reg == `PBC_IDX_CLR && w_strb_reg[0]) begin
        stat_reg <= (stat_reg & ~w_data_reg[3:0]) | hit;
      end else begin
        stat_reg <= stat_reg | hit;
      end
      if (wr_fire && aw_idx_reg == `PBC_IDX_IEN && w_strb_reg[0]) begin
        ien_reg <= w_data_reg[3:0];
      end
      if (wr_fire && aw_idx_reg == `PBC_IDX_STOP && w_strb_reg[0]) begin
        stop_reg <= w_data_reg[0];
      end
    end
  end
  // Level interrupt lags status by one cycle to stay a flop output
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_reg & ien_reg);
    end
  end
  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // Reserved control bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = mapped(ar_idx);
    for (int i = 0; i < 4; i++) begin
      if (ar_idx == IDX_BAH[i]) begin
        rd_data[15:0] = chan_reg[i].addr[31:16];
      end
      if (ar_idx == IDX_BAL[i]) begin
        rd_data[15:0] = chan_reg[i].addr[15:0];
      end
      if (ar_idx == IDX_BMH[i]) begin
        rd_data[15:0] = chan_reg[i].mask[31:16];
      end
      if (ar_idx == IDX_BML[i]) begin
        rd_data[15:0] = chan_reg[i].mask[15:0];
      end
      if (ar_idx == IDX_CTL[i]) begin
        rd_data[`PBC_CMF_BIT] = cmf_reg[i];
        rd_data[`PBC_CP_MSB:`PBC_CP_LSB] = chan_reg[i].ctrl.cp;
        rd_data[`PBC_ID_MSB:`PBC_ID_LSB] = chan_reg[i].ctrl.id;
        rd_data[`PBC_RW_MSB:`PBC_RW_LSB] = chan_reg[i].ctrl.rw;
      end
    end
    if (ar_idx == `PBC_IDX_STAT) begin
      rd_data[3:0] = stat_reg;
    end
    if (ar_idx == `PBC_IDX_IEN) begin
      rd_data[3:0] = ien_reg;
    end
    if (ar_idx == `PBC_IDX_STOP) begin
      rd_data[0] = stop_reg;
    end
  end
  // Single outstanding read, answered one cycle after the address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PBC_RESP_OK;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `PBC_RESP_OK : `PBC_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // ****************************************
  // Block-level checks
  // ****************************************
  a_break_after_hit:
    assert property (@(posedge clock) disable iff (!reset_n)
      ce && (|hit) |=> break_req)
    else $error("break missing after match");
  a_break_nonmask:
    assert property (@(posedge clock) disable iff (!reset_n)
      ce && (|hit) && ien_reg == 4'h0 |=> break_req && !irq)
    else $error("break gated by enables");
  a_break_fetch_time:
    assert property (@(posedge clock) disable iff (!reset_n)
      $rose(break_req) |-> $past(pc_valid))
    else $error("break not tied to a fetch");
  a_stop_no_match:
    assert property (@(posedge clock) disable iff (!reset_n)
      stop_reg |-> hit == 4'h0)
    else $error("match while stopped");
  a_standby_no_match:
    assert property (@(posedge clock) disable iff (!reset_n)
      ce && stby_sync_reg |=> !break_req)
    else $error("break during standby");
  a_chan_independent:
    assert property (@(posedge clock) disable iff (!reset_n)
      ce && hit[3] && hit[2:0] == 3'h0 |=> cmf_reg[3] && break_req)
    else $error("channel d alone failed");
endmodule : pbc_top

//--- shared/pbc_pkg.sv
package pbc_pkg;
  // ****************************************
  // Shared types
  // ****************************************
  typedef struct packed {
    logic [2:0] cp;
    logic [1:0] id;
    logic [1:0] rw;
  } pbc_ctrl_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] mask;
    pbc_ctrl_s ctrl;
  } pbc_chan_s;
  typedef logic [19:0] pbc_idx_t;
endpackage : pbc_pkg

//--- shared/pbc_regs.svh
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH
// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define PBC_IDX_A_BAH 20'hFFA00
`define PBC_IDX_A_BAL 20'hFFA02
`define PBC_IDX_A_BMH 20'hFFA04
`define PBC_IDX_A_BML 20'hFFA06
`define PBC_IDX_B_BAH 20'hFFA08
`define PBC_IDX_B_BAL 20'hFFA0A
`define PBC_IDX_B_BMH 20'hFFA0C
`define PBC_IDX_B_BML 20'hFFA0E
`define PBC_IDX_C_BAH 20'hFFA10
`define PBC_IDX_C_BAL 20'hFFA12
`define PBC_IDX_C_BMH 20'hFFA14
`define PBC_IDX_C_BML 20'hFFA16
`define PBC_IDX_D_BAH 20'hFFA18
`define PBC_IDX_D_BAL 20'hFFA1A
`define PBC_IDX_D_BMH 20'hFFA1C
`define PBC_IDX_D_BML 20'hFFA1E
`define PBC_IDX_A_CTL 20'hFFA28
`define PBC_IDX_B_CTL 20'hFFA2C
`define PBC_IDX_C_CTL 20'hFFA30
`define PBC_IDX_D_CTL 20'hFFA34
`define PBC_IDX_STAT 20'hFFA40
`define PBC_IDX_CLR 20'hFFA44
`define PBC_IDX_IEN 20'hFFA48
`define PBC_IDX_STOP 20'hFFA4C
// ****************************************
// Fields and values
// ****************************************
`define PBC_CMF_BIT 13
`define PBC_CP_MSB 11
`define PBC_CP_LSB 9
`define PBC_ID_MSB 5
`define PBC_ID_LSB 4
`define PBC_RW_MSB 3
`define PBC_RW_LSB 2
`define PBC_CP_OFF 3'h0
`define PBC_CP_CPU 3'h1
`define PBC_ID_OFF 2'h0
`define PBC_ID_PC 2'h1
`define PBC_RST16 16'h0000
`define PBC_RESP_OK 2'h0
`define PBC_RESP_ERR 2'h2
`endif

//--- verification/pbc_cpu_model.sv
`timescale 1ns/1ns
// ****************************************
// CPU fetch stream model
// ****************************************
module pbc_cpu_model (
  input wire logic clock,
  output logic [31:0] pc,
  output logic pc_valid
);
  // Idle values at time zero
  initial begin
    pc = 32'h00000000;
    pc_valid = 1'b0;
  end
  // One fetch cycle; pc is inverted afterwards so no stale address lingers
  task automatic fetch(input logic [31:0] a);
    @(posedge clock);
    pc <= a;
    pc_valid <= 1'b1;
    @(posedge clock);
    pc_valid <= 1'b0;
    pc <= ~a;
  endtask : fetch
endmodule : pbc_cpu_model

//--- verification/test_program_break_comparator.sv
`timescale 1ns/1ns
`include "pbc_regs.svh"
module test_program_break_comparator
  import pbc_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic standby = 1'b0;
  logic [31:0] pc;
  logic pc_valid;
  logic [21:0] awaddr = 22'h0, araddr = 22'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, break_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int checks = 0;
  // ****************************************
  // Clock, design and fetch model
  // ****************************************
  always #4 clock = ~clock;
  pbc_top i_pbc_top (.clock(clock), .reset_n(reset_n), .ce(ce), .pc(pc),
    .pc_valid(pc_valid), .standby(standby), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .break_req(break_req), .irq(irq));
  pbc_cpu_model i_pbc_cpu_model (.clock(clock), .pc(pc), .pc_valid(pc_valid));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bus write; address and data released separately as each is taken
  task automatic wr(input int idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    awaddr <= 22'(idx << 2);
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n == 50) begin
      miscompares++;
      close_out();
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input int idx, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clock);
    araddr <= 22'(idx << 2);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    if (n == 50) begin
      miscompares++;
      close_out();
    end
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", e, rdata);
  endtask : rd
  // Fetch, then look at the request in the cycle after and the one after that
  task automatic hit(input logic [31:0] a, input logic e);
    i_pbc_cpu_model.fetch(a);
    @(posedge clock);
    chk("break_req", {31'h0, e}, {31'h0, break_req});
    @(posedge clock);
    chk("break_req end", 32'h0, {31'h0, break_req});
  endtask : hit
  // Mask upper half must be loaded before the condition is enabled
  task automatic prog(input int ch, input logic [31:0] a, input logic [15:0] c);
    wr(`PBC_IDX_A_BAH + ch * 8, {16'h0, a[31:16]}, 2'h0);
    wr(`PBC_IDX_A_BAL + ch * 8, {16'h0, a[15:0]}, 2'h0);
    wr(`PBC_IDX_A_BMH + ch * 8, 32'h0000FF00, 2'h0);
    wr(`PBC_IDX_A_BML + ch * 8, 32'h00000000, 2'h0);
    wr(`PBC_IDX_A_CTL + ch * 4, {16'h0, c}, 2'h0);
  endtask : prog
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 4; k++) rd(`PBC_IDX_A_BAH + ch * 8 + k * 2, 32'h0, 2'h0);
      rd(`PBC_IDX_A_CTL + ch * 4, 32'h0, 2'h0);
    end
    rd(`PBC_IDX_STAT, 32'h0, 2'h0);
    rd(`PBC_IDX_IEN, 32'h0, 2'h0);
    rd(`PBC_IDX_STOP, 32'h0, 2'h0);
    rd(20'hFFA38, 32'h0, 2'h2);
    wr(20'hFFA38, 32'h1234, 2'h2);
  endtask : t_reset
  task automatic t_match();
    prog(0, 32'h12345678, 16'h0210);
    hit(32'h00345678, 1'b1);
    hit(32'hAB345678, 1'b1);
    hit(32'h00355678, 1'b0);
    hit(32'h00345679, 1'b0);
    wr(`PBC_IDX_A_CTL, 32'h00000210, 2'h0);
    rd(`PBC_IDX_A_CTL, 32'h00002210, 2'h0);
    wr(`PBC_IDX_A_CTL, 32'h00000210, 2'h0);
    rd(`PBC_IDX_A_CTL, 32'h00000210, 2'h0);
    rd(`PBC_IDX_STAT, 32'h1, 2'h0);
  endtask : t_match
  task automatic t_chans();
    for (int ch = 1; ch < 4; ch++) begin
      wr(`PBC_IDX_CLR, 32'hF, 2'h0);
      prog(ch, 32'h00001000 + ch * 16, 16'h0210);
      hit(32'h00001000 + ch * 16, 1'b1);
      rd(`PBC_IDX_STAT, 32'h1 << ch, 2'h0);
    end
  endtask : t_chans
  task automatic t_codes();
    for (int cp = 0; cp < 8; cp++) begin
      for (int id = 0; id < 4; id++) begin
        wr(`PBC_IDX_A_CTL, (cp << 9) | (id << 4), 2'h0);
        hit(32'h00345678, cp == 1 && id == 1);
      end
    end
    // Low-lane write must keep the upper control byte, then channel A is restored
    wr(`PBC_IDX_A_CTL, 32'h00000210, 2'h0);
    wstrb <= 4'h1;
    wr(`PBC_IDX_A_CTL, 32'h00000000, 2'h0);
    rd(`PBC_IDX_A_CTL, 32'h00002200, 2'h0);
    hit(32'h00345678, 1'b0);
    wstrb <= 4'hF;
    wr(`PBC_IDX_A_CTL, 32'h00000210, 2'h0);
  endtask : t_codes
  task automatic t_irq();
    wr(`PBC_IDX_CLR, 32'hF, 2'h0);
    wr(`PBC_IDX_IEN, 32'h0, 2'h0);
    hit(32'h00345678, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PBC_IDX_IEN, 32'h1, 2'h0);
    repeat (2) @(posedge clock);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`PBC_IDX_CLR, 32'h1, 2'h0);
    repeat (2) @(posedge clock);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(`PBC_IDX_STAT, 32'h0, 2'h0);
  endtask : t_irq
  task automatic t_stop();
    wr(`PBC_IDX_STOP, 32'h1, 2'h0);
    hit(32'h00345678, 1'b0);
    wr(`PBC_IDX_STOP, 32'h0, 2'h0);
    @(posedge clock);
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    hit(32'h00345678, 1'b0);
    standby <= 1'b0;
    repeat (3) @(posedge clock);
    hit(32'h00345678, 1'b1);
  endtask : t_stop
  // Reset values of every bus and link output
  task automatic t_outs();
    chk("outs", 32'h70, {25'h0, awready, wready, arready, bvalid, rvalid, break_req, irq});
    chk("reset resp", 32'h0, {28'h0, bresp, rresp});
    chk("reset rdata", 32'h0, rdata);
  endtask : t_outs
  // Clock enable low freezes matching and status
  task automatic t_freeze();
    wr(`PBC_IDX_CLR, 32'hF, 2'h0);
    ce <= 1'b0;
    hit(32'h00345678, 1'b0);
    ce <= 1'b1;
    rd(`PBC_IDX_STAT, 32'h0, 2'h0);
    hit(32'h00345678, 1'b1);
  endtask : t_freeze
  // Mid-run reset brings outputs back to reset values (ready outputs high) and registers back to zero
  task automatic t_rereset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    t_outs();
    reset_n <= 1'b1;
    rd(`PBC_IDX_A_CTL, 32'h0, 2'h0);
    rd(`PBC_IDX_A_BMH, 32'h0, 2'h0);
    rd(`PBC_IDX_STAT, 32'h0, 2'h0);
  endtask : t_rereset
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    t_outs();
    reset_n <= 1'b1;
    t_reset();
    t_match();
    t_chans();
    t_codes();
    t_irq();
    t_stop();
    t_freeze();
    t_rereset();
    close_out();
  end
endmodule : test_program_break_comparator
